// *** tb/sfd_props.sv ***
// link checker for the serial exchange between the two ends
`timescale 1ns/1ps
module sfd_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // link
  input wire logic sclk,
  input wire logic miso_oe,
  input wire logic sel_n
);
  logic [7:0] edges_r;
  logic [7:0] quiet_r;
  logic       sclk_r;

  // clock toggles inside one select, and cycles since the last toggle
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      edges_r <= 8'h00;
      quiet_r <= 8'h00;
      sclk_r  <= 1'h0;
    end
    else
    begin
      sclk_r  <= sclk;
      edges_r <= sel_n ? 8'h00 : edges_r + {7'h00, sclk ^ sclk_r};
      quiet_r <= (sclk ^ sclk_r) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // slave sees select through a synchroniser, so allow it a few cycles
  property p_oe_off; sel_n [*4] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("slave drives while deselected");
  property p_oe_on; $fell(sel_n) |-> ##[1:4] miso_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("slave output not driven");
  property p_first_wait; $fell(sel_n) |-> $stable(sclk) [*8]; endproperty
  a_first_wait: assert property (p_first_wait) else $error("clock before setup");
  property p_half_min; $changed(sclk) && !sel_n |=> $stable(sclk) [*8]; endproperty
  a_half_min: assert property (p_half_min) else $error("clock half too short");
  property p_half_max;
    $changed(sclk) && !sel_n |-> ##[9:12] ($changed(sclk) || $rose(sel_n));
  endproperty
  a_half_max: assert property (p_half_max) else $error("clock stalled");
  property p_byte_whole; $rose(sel_n) |-> edges_r[3:0] == 4'h0 && edges_r != 8'h00; endproperty
  a_byte_whole: assert property (p_byte_whole) else $error("partial byte");
  property p_stop_first; $rose(sel_n) |-> quiet_r >= 8'h08; endproperty
  a_stop_first: assert property (p_stop_first) else $error("deselect too soon");
  property p_sel_hold; $fell(sel_n) |=> !sel_n [*8]; endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select dropped early");

  cover property ($rose(sel_n) && edges_r > 8'h10);
  cover property ($fell(sel_n));
  cover property (miso_oe && $changed(sclk));
endmodule

// *** tb/spi_full_duplex_shifter_test.sv ***
// self-checking bench joining the master end and the slave end
`timescale 1ns/1ps
module spi_full_duplex_shifter_test;
  import sfd_pkg::*;
  typedef struct packed {logic cp; logic ch; logic [7:0] md; logic [7:0] sd;} sfd_row_t;
  logic       clk_in = 1'h0;
  logic       resetn_in = 1'h0;
  logic       cpol = 1'h0;
  logic       cpha = 1'h0;
  logic       m_valid = 1'h0;
  logic       m_read = 1'h0;
  logic       s_wr = 1'h0;
  logic       s_clr = 1'h0;
  logic       s_read = 1'h0;
  logic [7:0] m_data = 8'h00;
  logic [7:0] s_data = 8'h00;
  logic       m_ready, m_full, m_irq, m_busy, s_full, s_irq, s_write_collision_flag;
  logic [7:0] m_rx, s_rx;
  logic [7:0] sq[$];
  logic [7:0] pq[$];
  int         mismatches = 0;
  int         comparisons = 0;
  int         mi = 0;
  int         t, n;
  sfd_row_t   rows [4] = '{'{1'h0, 1'h0, 8'hA5, 8'h3C}, '{1'h0, 1'h1, 8'h01, 8'h80},
                           '{1'h1, 1'h0, 8'hFF, 8'h00}, '{1'h1, 1'h1, 8'h96, 8'h69}};

  always #2.5 clk_in = ~clk_in;

  sfd_link_if u_sfd_link_if ();
  wire sel_n = u_sfd_link_if.sel_n;
  sfd_master u_sfd_master (.clk_in(clk_in), .resetn_in(resetn_in), .cpol_in(cpol),
    .cpha_in(cpha), .tx_valid_in(m_valid), .tx_data_in(m_data), .tx_ready_out(m_ready),
    .rx_data_out(m_rx), .rx_full_out(m_full), .rx_irq_out(m_irq), .rx_read_in(m_read),
    .busy_out(m_busy), .link(u_sfd_link_if.master));
  sfd_slave u_sfd_slave (.clk_in(clk_in), .resetn_in(resetn_in), .cpol_in(cpol),
    .cpha_in(cpha), .wr_in(s_wr), .wr_data_in(s_data), .write_collision_flag_clr_in(s_clr),
    .rx_read_in(s_read), .rx_data_out(s_rx), .rx_full_out(s_full), .rx_irq_out(s_irq),
    .write_collision_flag_out(s_write_collision_flag), .link(u_sfd_link_if.slave));
  sfd_props u_sfd_props (.clk_in(clk_in), .resetn_in(resetn_in),
    .sclk(u_sfd_link_if.sclk), .miso_oe(u_sfd_link_if.miso_oe), .sel_n(sel_n));

  always @(posedge clk_in)
  begin
    if (s_irq === 1'h1)
      sq.push_back(s_rx);
    if (m_irq === 1'h1)
      mi++;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
  begin
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  end
  endtask

  task automatic complete_run;
  begin
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // polarity only changes inside reset; with cpol 1 the clock rises after reset, while the slave is still deselected
  task automatic rst(input logic p, input logic h);
  begin
    resetn_in = 1'h0;
    cpol = p;
    cpha = h;
    repeat (3) @(posedge clk_in);
    #1 resetn_in = 1'h1;
  end
  endtask

  task automatic pulse(ref logic s);
  begin
    s = 1'h1;
    @(posedge clk_in);
    #1 s = 1'h0;
  end
  endtask

  task automatic push(input logic [7:0] b);
  begin
    m_valid = 1'h1;
    m_data = b;
    @(posedge clk_in);
    for (t = 0; t < 20 && m_ready !== 1'h1; t++) @(posedge clk_in);
    #1 m_valid = 1'h0;
  end
  endtask

  // slave settles a few cycles after deselect through its synchroniser
  task automatic wait_done;
  begin
    for (t = 0; t < 20 && sel_n !== 1'h0; t++) @(posedge clk_in);
    for (t = 0; t < 3000 && sel_n !== 1'h1; t++) @(posedge clk_in);
    chk("frame end", 8'h01, {7'h00, sel_n});
    repeat (4) @(posedge clk_in);
    #1;
  end
  endtask

  initial
  begin
    for (n = 0; n < 4; n++)
    begin
      rst(rows[n].cp, rows[n].ch);
      s_data = rows[n].sd;
      pulse(s_wr);
      push(rows[n].md);
      wait_done;
      chk("master rx", rows[n].sd, m_rx);
      chk("slave rx", rows[n].md, s_rx);
      chk("full", 8'h03, {6'h00, m_full, s_full});
      chk("irq count", 8'(n + 1), 8'(mi));
      chk("clock idle", {7'h00, rows[n].cp}, {7'h00, u_sfd_link_if.sclk});
      m_read = 1'h1;
      pulse(s_read);
      m_read = 1'h0;
      chk("full clear", 8'h00, {6'h00, m_full, s_full});
    end
    rst(1'h0, 1'h0);
    s_data = 8'h5A;
    pulse(s_wr);
    push(8'hC3);
    repeat (40) @(posedge clk_in);
    #1 s_data = 8'hEE;
    pulse(s_wr);
    wait_done;
    chk("collision", 8'h01, {7'h00, s_write_collision_flag});
    chk("master rx kept", 8'h5A, m_rx);
    pulse(s_clr);
    chk("collision clear", 8'h00, {7'h00, s_write_collision_flag});
    sq.delete();
    m_valid = 1'h1;
    for (n = 0; n < 12; n++)
    begin
      m_data = 8'(8'h30 + pq.size());
      @(posedge clk_in);
      if (m_ready === 1'h1)
        pq.push_back(m_data);
      #1;
    end
    m_valid = 1'h0;
    chk("refused", 8'h00, {7'h00, m_ready});
    chk("depth", 8'h01, {7'h00, pq.size() >= SFD_FIFO_DEP && pq.size() <= 10});
    wait_done;
    chk("bytes", 8'(pq.size()), 8'(sq.size()));
    foreach (pq[i]) chk("burst", pq[i], sq[i]);
    push(8'h81);
    repeat (50) @(posedge clk_in);
    #1 resetn_in = 1'h0;
    #1 chk("reset", 8'h01, {1'h0, m_busy, m_full, s_full, s_write_collision_flag, u_sfd_link_if.sclk,
      u_sfd_link_if.miso_oe, sel_n});
    rst(1'h0, 1'h0);
    complete_run;
  end

  initial
  begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule

// *** verilog/sfd_fifo.sv ***
// small valid/ready fifo used on the master's transmit path
`timescale 1ns/1ps
module sfd_fifo
  import sfd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = SFD_FIFO_DEP
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sfd_fifo_st_t;
  sfd_fifo_st_t        s_r;
  sfd_fifo_st_t        s_nxt;
  logic [WIDTH-1:0]    mem_r [DEPTH];
  logic                push;
  logic                pop;

  assign in_ready_out  = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid_out = s_r.cnt != '0;
  assign out_data_out  = mem_r[s_r.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_r[s_r.wp] <= in_data_in;
    end
  end
endmodule

// *** verilog/sfd_link_if.sv ***
// wires between the master end and the slave end
`timescale 1ns/1ps
interface sfd_link_if;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  logic sel_n;
  // released line reads high when no slave drives it
  assign miso = miso_oe ? miso_o : 1'b1;
  modport master (output sclk, output mosi, input miso, output sel_n);
  modport slave  (input sclk, input mosi, output miso_o, output miso_oe, input sel_n);
endinterface

// *** verilog/sfd_master.sv ***
// master end: fifo-fed byte exchanger that makes the serial clock
`timescale 1ns/1ps
module sfd_master
  import sfd_pkg::*;
#(
  parameter int HALF_DIV = SFD_HALF_DIV
)(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // configuration
  input  wire logic       cpol_in,
  input  wire logic       cpha_in,
  // transmit stream
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  // received bytes
  output logic [7:0]      rx_data_out,
  output logic            rx_full_out,
  output logic            rx_irq_out,
  input  wire logic       rx_read_in,
  output logic            busy_out,
  // link
  sfd_link_if.master      link
);
  typedef enum logic [1:0] {M_IDLE, M_LEAD, M_RUN, M_TAIL} sfd_mst_t;
  typedef struct packed {
    sfd_mst_t   st;
    logic [7:0] div;
    logic [3:0] cnt;
    logic       ph;
    logic [7:0] shr;                                      // [R2]
    logic       dout;
    logic       smp;
    logic [7:0] buf_q;
    logic       full;
    logic       irq;
    logic       sclk;
    logic       sel_n;
    logic       miso1;
    logic       miso2;
  } sfd_mst_st_t;
  sfd_mst_st_t s_r;
  sfd_mst_st_t s_nxt;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_take;
  logic        tick;
  logic        rx_bit;

  sfd_fifo #(.WIDTH(8), .DEPTH(SFD_FIFO_DEP)) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_data_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (f_take)
  );

  assign tick   = s_r.div == 8'(HALF_DIV - 1);
  // cpha=0 holds the bit taken on the leading edge until the trailing shift
  assign rx_bit = cpha_in ? s_r.miso2 : s_r.smp;
  // fifo stalls while a byte is in flight [R18]
  assign f_take = (s_r.st == M_IDLE || (s_r.st == M_RUN && tick && s_r.ph
                  && s_r.cnt == 4'(SFD_BITS - 1))) && f_valid;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.miso1 = link.miso;
    s_nxt.miso2 = s_r.miso1;
    s_nxt.div   = tick ? SFD_DIV_RST : s_r.div + 8'h01;
    if (rx_read_in)
    begin
      s_nxt.full = 1'b0;                                  // [R19]
    end
    s_nxt.irq = 1'b0;
    case (s_r.st)
      M_IDLE:
      begin
        s_nxt.sclk = cpol_in;                             // [R7]
        if (f_valid)
        begin
          s_nxt.shr   = f_data;                           // [R16]
          s_nxt.dout  = f_data[7];
          s_nxt.sel_n = 1'b0;
          s_nxt.st    = M_LEAD;
          s_nxt.div   = SFD_DIV_RST;
          s_nxt.cnt   = SFD_CNT_RST;
          s_nxt.ph    = 1'b0;
        end
      end
      M_LEAD:
      begin
        if (tick)
        begin
          s_nxt.st = M_RUN;
        end
      end
      M_RUN:
      begin
        if (tick)
        begin
          // cpha=0: sample on first edge, shift on second; cpha=1 the reverse [R4]
          if (cpha_in == s_r.ph)
          begin
            s_nxt.smp = s_r.miso2;
          end
          if (cpha_in && !s_r.ph)
          begin
            s_nxt.dout = s_r.shr[7];
          end
          if (s_r.ph)
          begin
            s_nxt.shr  = {s_r.shr[6:0], rx_bit};          // [R3] [R1]
            s_nxt.dout = cpha_in ? s_r.dout : s_r.shr[6];
          end
          s_nxt.ph = !s_r.ph;
          if (s_r.ph && s_r.cnt == 4'(SFD_BITS - 1))
          begin
            s_nxt.buf_q = {s_r.shr[6:0], rx_bit};         // [R9]
            s_nxt.full  = 1'b1;                           // [R17]
            s_nxt.irq   = 1'b1;
            s_nxt.sclk  = cpol_in;
            s_nxt.cnt   = SFD_CNT_RST;
            if (f_valid)
            begin
              s_nxt.shr  = f_data;                        // [R10]
              s_nxt.dout = f_data[7];
            end
            else
            begin
              s_nxt.st = M_TAIL;                          // [R11]
            end
          end
          else
          begin
            s_nxt.sclk = !s_r.sclk;                       // [R6]
            if (s_r.ph)
            begin
              s_nxt.cnt = s_r.cnt + 4'h1;
            end
          end
        end
      end
      M_TAIL:
      begin
        if (tick)
        begin
          s_nxt.sel_n = 1'b1;                             // [R11] [R13]
          s_nxt.st    = M_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_r       <= '0;                                    // [R20]
      s_r.st    <= M_IDLE;
      s_r.sclk  <= SFD_CPOL_DEF;
      s_r.sel_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // master out is msb of its shifter [R5] [R8]
  // this end is the only clock source on the link [R15]
  assign link.mosi  = s_r.dout;
  assign link.sclk  = s_r.sclk;
  assign link.sel_n = s_r.sel_n;
  assign rx_data_out = s_r.buf_q;
  assign rx_full_out = s_r.full;
  assign rx_irq_out  = s_r.irq;
  assign busy_out    = s_r.st != M_IDLE;
endmodule

// *** verilog/sfd_pkg.sv ***
// constants shared by both ends of the serial exchange link
// How it works
// R1 - one bit each way every clock
// R2 - eight-bit shift register on each side
// R3 - msb out first, new bit into lsb
// R4 - drive on one edge, sample on other
// R5 - master out feeds slave in, and back
// R6 - only the master makes the clock
// R7 - both sides share one clock polarity
// R8 - master msb lands in slave lsb
// R9 - eight clocks swap whole registers
// R10 - reload between bytes, else dummy exchanged
// R11 - stop clock, then deselect slave
// R12 - unselected slave ignores clock and data
// R13 - master selects at most one slave
// R14 - unselected slave output goes high impedance
// R15 - exactly one master on the bus
// R16 - master starts once buffer is written
// R17 - full byte sets buffer-full and irq flag
// R18 - write during transfer ignored, sets collision
// R19 - buffer read clears buffer-full flag
// R20 - reset clears shifter, counter, flags, clock idle (master reset drives the clock to SFD_CPOL_DEF, low, whatever cpol_in is)
package sfd_pkg;
  localparam int          SFD_BITS      = 8;
  localparam logic [3:0]  SFD_CNT_RST   = 4'h0;
  localparam logic [7:0]  SFD_BYTE_RST  = 8'h00;
  // master half-period of the serial clock in system clocks
  localparam int          SFD_HALF_DIV  = 10;
  localparam logic [7:0]  SFD_DIV_RST   = 8'h00;
  localparam int          SFD_FIFO_DEP  = 8;
  localparam logic        SFD_CPOL_DEF  = 1'b0;
endpackage

// *** verilog/sfd_slave.sv ***
// slave end: byte exchanger on clk_in that follows synchronised edges of the master's serial clock
`timescale 1ns/1ps
module sfd_slave
  import sfd_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // configuration
  input  wire logic       cpol_in,
  input  wire logic       cpha_in,
  // user side
  input  wire logic       wr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       write_collision_flag_clr_in,
  input  wire logic       rx_read_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_full_out,
  output logic            rx_irq_out,
  output logic            write_collision_flag_out,
  // link
  sfd_link_if.slave       link
);
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] sel_s;
    logic       sck_d;
    logic [3:0] cnt;
    logic [7:0] shr;                                      // [R2] [R15]
    logic [7:0] buf_q;
    logic       full;
    logic       irq;
    logic       write_collision_flag;
    logic       dout;
  } sfd_slv_st_t;
  sfd_slv_st_t s_r;
  sfd_slv_st_t s_nxt;
  logic        sel;
  logic        lead;
  logic        trail;
  logic        samp;
  logic        shift;
  logic        active;

  assign sel    = !s_r.sel_s[1];
  assign lead   = (s_r.sck_s[1] != s_r.sck_d) && (s_r.sck_d == cpol_in);
  assign trail  = (s_r.sck_s[1] != s_r.sck_d) && (s_r.sck_d != cpol_in);
  assign samp   = sel && (cpha_in ? trail : lead);      // [R4] [R12]
  assign shift  = sel && (cpha_in ? lead : trail);
  assign active = sel && s_r.cnt != SFD_CNT_RST;

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.sck_s  = {s_r.sck_s[0], link.sclk};
    s_nxt.mosi_s = {s_r.mosi_s[0], link.mosi};
    s_nxt.sel_s  = {s_r.sel_s[0], link.sel_n};
    s_nxt.sck_d  = s_r.sck_s[1];
    s_nxt.irq    = 1'b0;
    if (rx_read_in)
    begin
      s_nxt.full = 1'b0;                                  // [R19]
    end
    if (write_collision_flag_clr_in)
    begin
      s_nxt.write_collision_flag = 1'b0;
    end
    if (!sel)
    begin
      s_nxt.cnt  = SFD_CNT_RST;                           // [R12]
      s_nxt.dout = s_r.shr[7];
    end
    if (samp)
    begin
      s_nxt.shr = {s_r.shr[6:0], s_r.mosi_s[1]};          // [R3] [R8]
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_r.cnt == 4'(SFD_BITS - 1))
      begin
        s_nxt.buf_q = {s_r.shr[6:0], s_r.mosi_s[1]};      // [R9]
        s_nxt.full  = 1'b1;                               // [R17]
        s_nxt.irq   = 1'b1;
        s_nxt.cnt   = SFD_CNT_RST;
      end
    end
    if (shift)
    begin
      s_nxt.dout = s_r.shr[7];                            // [R1]
    end
    if (wr_in)
    begin
      // a write inside a byte is dropped; the set wins over a clear [R18]
      if (active || s_r.write_collision_flag)
      begin
        s_nxt.write_collision_flag = 1'b1;
      end
      else
      begin
        s_nxt.shr  = wr_data_in;                          // [R10]
        s_nxt.dout = wr_data_in[7];
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_r       <= '0;                                    // [R20]
      s_r.sel_s <= 2'b11;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign link.miso_o  = s_r.dout;                         // [R5]
  assign link.miso_oe = sel;                              // [R14]
  assign rx_data_out  = s_r.buf_q;
  assign rx_full_out  = s_r.full;
  assign rx_irq_out   = s_r.irq;
  assign write_collision_flag_out     = s_r.write_collision_flag;
endmodule
